// File: hw/host_bus_if.sv
// Pins of the host bus between the host end and the device end.
// Assumes both ends share sys_clk; the data wire level is resolved here.
`timescale 1ns/1ps
interface host_bus_if;
  import host_bus_pkg::*;

  logic              host_select_n;
  logic              read_strobe_n;
  logic              write_strobe_n;
  logic              fifo_direct_select;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_data_out;
  logic              host_data_oe;
  logic [DATA_W-1:0] dev_data_out;
  logic              dev_data_oe;
  logic [DATA_W-1:0] data_bus;

  // An undriven bus floats to the pull-up value.
  assign data_bus = dev_data_oe  ? dev_data_out  :
                    host_data_oe ? host_data_out : BUS_PULL_VALUE;

  modport device (
    input  host_select_n, read_strobe_n, write_strobe_n, fifo_direct_select, addr,
    input  data_bus,
    output dev_data_out, dev_data_oe
  );

  modport host (
    output host_select_n, read_strobe_n, write_strobe_n, fifo_direct_select, addr,
    output host_data_out, host_data_oe,
    input  data_bus
  );

endinterface : host_bus_if

// File: hw/host_bus_pkg.sv
// Shared constants and types for the asynchronous 16-bit host bus port.
// Assumes both ends run on one 25 MHz clock and meet through host_bus_if.
package host_bus_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 7;

  // Bus timing in nanoseconds and the clock period.
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_CYCLE_NS    = 45;
  localparam int T_ASSERT_NS   = 32;
  localparam int T_RELEASE_NS  = 13;

  // Least times round up to whole clock cycles.
  localparam int CYCLE_CYC   = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ASSERT_CYC  = (T_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC = (T_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Edges from a new address to registered read data at the pins.
  localparam int READ_LAT_CYC = 3;

  // Word address map, in units of 16-bit words on address bits 7:1.
  localparam logic [6:0] RXD_BASE  = 7'h00;
  localparam logic [6:0] RXD_LAST  = 7'h0F;
  localparam logic [6:0] RXS_BASE  = 7'h20;
  localparam logic [6:0] RXS_LAST  = 7'h21;
  localparam logic [6:0] TXS_BASE  = 7'h24;
  localparam logic [6:0] TXS_LAST  = 7'h25;
  localparam logic [6:0] CSR_BASE  = 7'h28;

  localparam int          BURST_MAX_WORDS = 16;
  localparam logic [15:0] IDLE_DATA       = 16'h0000;
  localparam logic [15:0] BUS_PULL_VALUE  = 16'hFFFF;

  typedef enum logic [2:0] {
    TGT_NONE = 3'h0,
    TGT_CSR  = 3'h1,
    TGT_RXD  = 3'h2,
    TGT_RXS  = 3'h3,
    TGT_TXS  = 3'h4
  } target_t;

  typedef enum logic [1:0] {
    DEV_IDLE  = 2'b00,
    DEV_READ  = 2'b01,
    DEV_WRITE = 2'b10
  } dev_state_t;

  typedef enum logic [1:0] {
    HST_IDLE    = 2'b00,
    HST_ACCESS  = 2'b01,
    HST_RELEASE = 2'b11
  } host_state_t;

  function automatic int max_int(input int a, input int b);
    max_int = (a > b) ? a : b;
  endfunction : max_int

  // Time a host keeps one word on the bus before stepping or releasing.
  localparam int STEP_CYC = max_int(max_int(CYCLE_CYC, ASSERT_CYC), READ_LAT_CYC + 1);

endpackage : host_bus_pkg

// File: hw/host_port_device.sv
// Device end of the asynchronous 16-bit host bus: decodes reads and writes
// onto internal register and FIFO ports.
// Assumes the host runs on sys_clk and keeps its own timing obligations.
//
// Summary of operation
// - Reads reach registers, data FIFO, status FIFOs.
// - Counters latched at read cycle start.
// - Read starts both low, ends either high.
// - Host keeps reads long enough.
// - Host releases strobes between single reads.
// - Each transfer moves one 16-bit word.
// - Normal burst: up to 16 words.
// - Host releases strobes between bursts.
// - Burst starts both low, ends either high.
// - Direct select reads always hit data FIFO.
// - Direct mode keeps A[2:1], drops A[7:3]; direct writes keep A[7:3] on csr_wr_addr.
// - Direct select timed like address lines.
// - Direct burst has no length limit.
// - Host releases strobes after direct burst.
// - Writes start both low, end either high.
// - Host keeps write timing minimums.
`timescale 1ns/1ps
module host_port_device
  import host_bus_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  host_bus_if.device             bus,
  output logic [ADDR_W-1:0]      csr_addr,
  input  wire logic [DATA_W-1:0] csr_rd_data,
  output logic                   counter_latch,
  output logic                   csr_wr_en,
  output logic [ADDR_W-1:0]      csr_wr_addr,
  output logic [DATA_W-1:0]      csr_wr_data,
  output logic                   csr_wr_fifo_sel,
  input  wire logic [DATA_W-1:0] rx_data_word,
  output logic [1:0]             rx_data_lane,
  output logic                   rx_data_pop,
  input  wire logic [DATA_W-1:0] rx_status_word,
  output logic                   rx_status_pop,
  input  wire logic [DATA_W-1:0] tx_status_word,
  output logic                   tx_status_pop,
  output logic                   burst_overrun
);

  // Decodes one word address into the resource that it reaches.
  function automatic target_t decode_target(input logic [ADDR_W-1:0] a,
                                            input logic              direct);
    if (direct)
      decode_target = TGT_RXD;
    else if (a >= RXD_BASE && a <= RXD_LAST)
      decode_target = TGT_RXD;
    else if (a >= RXS_BASE && a <= RXS_LAST)
      decode_target = TGT_RXS;
    else if (a >= TXS_BASE && a <= TXS_LAST)
      decode_target = TGT_TXS;
    else if (a >= CSR_BASE)
      decode_target = TGT_CSR;
    else
      decode_target = TGT_NONE;
  endfunction : decode_target

  // keep only A[2:1] in direct mode
  function automatic logic [ADDR_W-1:0] effective_addr(input logic [ADDR_W-1:0] a,
                                                       input logic              direct);
    effective_addr = direct ? {5'h00, a[1:0]} : a;
  endfunction : effective_addr

  dev_state_t        state_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              direct_reg;
  target_t           target_reg;
  logic [1:0]        load_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [4:0]        word_count_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic              wr_direct_reg;

  logic              read_active;
  logic              write_active;
  logic [ADDR_W-1:0] cur_addr;
  logic              read_start;
  logic              addr_step;
  logic              word_done;
  logic              new_word;
  logic              write_end;

  assign read_active  = !bus.host_select_n && !bus.read_strobe_n;
  assign write_active = !bus.host_select_n && !bus.write_strobe_n;
  assign cur_addr     = effective_addr(bus.addr, bus.fifo_direct_select);
  assign read_start = (state_reg == DEV_IDLE) && read_active;
  // next burst word on address change
  assign addr_step  = (state_reg == DEV_READ) && read_active &&
                      ((cur_addr != addr_reg) || (bus.fifo_direct_select != direct_reg));
  // burst ends when either strobe rises
  assign word_done  = (state_reg == DEV_READ) && (!read_active || addr_step);
  assign new_word   = read_start || addr_step;
  assign write_end  = (state_reg == DEV_WRITE) && !write_active;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      state_reg <= DEV_IDLE;
    else
    begin
      case (state_reg)
        DEV_IDLE:
        begin
          if (read_active)
            state_reg <= DEV_READ;
          else if (write_active)
            state_reg <= DEV_WRITE;
        end
        DEV_READ:
        begin
          if (!read_active)
            state_reg <= DEV_IDLE;
        end
        DEV_WRITE:
        begin
          if (!write_active)
            state_reg <= DEV_IDLE;
        end
        default:
          state_reg <= DEV_IDLE;
      endcase
    end
  end

  // Address and target of the word being read.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      addr_reg   <= '0;
      direct_reg <= 1'b0;
      target_reg <= TGT_NONE;
    end
    else if (new_word)
    begin
      addr_reg   <= cur_addr;
      direct_reg <= bus.fifo_direct_select;
      target_reg <= decode_target(bus.addr, bus.fifo_direct_select);
    end
  end

  // Read data is fetched on the third edge after a new word, once its pop has landed.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      load_reg <= '0;
    else
      load_reg <= {load_reg[0], new_word};
  end

  // value held stable for the word
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      rdata_reg <= IDLE_DATA;
    else if (load_reg[1] && state_reg == DEV_READ)
    begin
      case (target_reg)
        TGT_CSR: rdata_reg <= csr_rd_data;
        TGT_RXD: rdata_reg <= rx_data_word;
        TGT_RXS: rdata_reg <= rx_status_word;
        TGT_TXS: rdata_reg <= tx_status_word;
        default: rdata_reg <= IDLE_DATA;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      counter_latch <= 1'b0;
    else
      counter_latch <= read_start;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rx_data_pop   <= 1'b0;
      rx_status_pop <= 1'b0;
      tx_status_pop <= 1'b0;
    end
    else
    begin
      rx_data_pop   <= word_done && (target_reg == TGT_RXD);
      rx_status_pop <= word_done && (target_reg == TGT_RXS);
      tx_status_pop <= word_done && (target_reg == TGT_TXS);
    end
  end

  // direct bursts are never counted against the limit
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      word_count_reg <= '0;
      burst_overrun  <= 1'b0;
    end
    else if (read_start)
    begin
      word_count_reg <= 5'h01;
      burst_overrun  <= 1'b0;
    end
    else if (addr_step && !bus.fifo_direct_select)
    begin
      // flag a normal burst past 16 words
      if (word_count_reg == 5'(BURST_MAX_WORDS))
        burst_overrun <= 1'b1;
      else
        word_count_reg <= word_count_reg + 5'h01;
    end
  end

  // Write address and data follow the pins while the write is asserted.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_addr_reg   <= '0;
      wr_data_reg   <= '0;
      wr_direct_reg <= 1'b0;
    end
    else if (write_active && !read_active)
    begin
      wr_addr_reg   <= bus.addr;
      wr_data_reg   <= bus.data_bus;
      wr_direct_reg <= bus.fifo_direct_select;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      csr_wr_en       <= 1'b0;
      csr_wr_addr     <= '0;
      csr_wr_data     <= '0;
      csr_wr_fifo_sel <= 1'b0;
    end
    else
    begin
      csr_wr_en <= write_end;
      if (write_end)
      begin
        csr_wr_addr     <= wr_addr_reg;
        csr_wr_data     <= wr_data_reg;
        csr_wr_fifo_sel <= wr_direct_reg;
      end
    end
  end

  assign csr_addr         = addr_reg;
  assign rx_data_lane     = addr_reg[1:0];
  assign bus.dev_data_out = rdata_reg;
  // drive only inside a read cycle
  assign bus.dev_data_oe  = read_active && (state_reg == DEV_READ);
endmodule : host_port_device

// File: hw/host_port_master.sv
// Host end of the asynchronous 16-bit host bus: turns user commands into
// single writes and single or burst reads with the required spacing.
// Assumes the device end answers within READ_LAT_CYC edges of an address.
`timescale 1ns/1ps
module host_port_master
  import host_bus_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  host_bus_if.host               bus,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic              cmd_write,
  input  wire logic              cmd_direct,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  input  wire logic [7:0]        cmd_words,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data
);

  host_state_t       state_reg;
  logic [3:0]        cyc_reg;
  logic [7:0]        left_reg;
  logic              write_reg;
  logic              select_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              direct_reg;
  logic [7:0]        words;
  logic              step_end;

  // normal bursts clamp at 16, direct ones do not
  assign words = (cmd_direct || cmd_write) ? ((cmd_words == 8'h00) ? 8'h01 : cmd_words) :
                 (cmd_words == 8'h00) ? 8'h01 :
                 (cmd_words > 8'(BURST_MAX_WORDS)) ? 8'(BURST_MAX_WORDS) : cmd_words;
  assign step_end  = (state_reg == HST_ACCESS) && (cyc_reg == 4'(STEP_CYC - 1));
  assign cmd_ready = (state_reg == HST_IDLE);

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg  <= HST_IDLE;
      cyc_reg    <= '0;
      left_reg   <= '0;
      write_reg  <= 1'b0;
      select_reg <= 1'b0;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      direct_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        HST_IDLE:
        begin
          if (cmd_valid)
          begin
            state_reg  <= HST_ACCESS;
            cyc_reg    <= '0;
            left_reg   <= cmd_write ? 8'h01 : words;
            write_reg  <= cmd_write;
            select_reg <= 1'b1;
            addr_reg   <= cmd_addr;
            wdata_reg  <= cmd_wdata;
            direct_reg <= cmd_direct;
          end
        end
        HST_ACCESS:
        begin
          if (step_end)
          begin
            cyc_reg <= '0;
            if (left_reg == 8'h01)
            begin
              state_reg  <= HST_RELEASE;
              select_reg <= 1'b0;
            end
            else
            begin
              left_reg <= left_reg - 8'h01;
              addr_reg <= addr_reg + 7'h01;
            end
          end
          else
            cyc_reg <= cyc_reg + 4'h1;
        end
        HST_RELEASE:
        begin
          if (cyc_reg == 4'(RELEASE_CYC - 1))
          begin
            state_reg <= HST_IDLE;
            cyc_reg   <= '0;
          end
          else
            cyc_reg <= cyc_reg + 4'h1;
        end
        default:
          state_reg <= HST_IDLE;
      endcase
    end
  end

  // one word sampled per read step
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end
    else
    begin
      rsp_valid <= step_end && !write_reg;
      if (step_end && !write_reg)
        rsp_data <= bus.data_bus;
    end
  end

  assign bus.host_select_n      = !select_reg;
  assign bus.read_strobe_n      = !(select_reg && !write_reg);
  assign bus.write_strobe_n     = !(select_reg && write_reg);
  assign bus.fifo_direct_select = direct_reg;
  assign bus.addr               = addr_reg;
  assign bus.host_data_out      = wdata_reg;
  assign bus.host_data_oe       = select_reg && write_reg;

endmodule : host_port_master

// File: test/host_bus_monitor.sv
// Assertions on the host bus pins between the host end and the device end.
// Assumes one clock for both ends and an active high asynchronous reset.
`timescale 1ns/1ps
module host_bus_monitor
  import host_bus_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic              host_select_n,
  input wire logic              read_strobe_n,
  input wire logic              write_strobe_n,
  input wire logic              fifo_direct_select,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] host_data_out,
  input wire logic              host_data_oe,
  input wire logic [DATA_W-1:0] dev_data_out,
  input wire logic              dev_data_oe,
  input wire logic [DATA_W-1:0] data_bus
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire rd_on = !host_select_n && !read_strobe_n;
  wire wr_on = !host_select_n && !write_strobe_n;
  wire act   = rd_on || wr_on;

  chk_oe_needs_read: assert property (dev_data_oe |-> rd_on)
    else $error("device drives bus outside a read");
  chk_oe_follows_read: assert property (rd_on [*3] |-> dev_data_oe)
    else $error("device silent during a read");
  chk_bus_one_driver: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data bus");
  chk_write_data_driven: assert property (wr_on |-> host_data_oe && !dev_data_oe
    && data_bus == host_data_out)
    else $error("write without host data");
  chk_strobe_length: assert property ($rose(act) |=> act)
    else $error("strobe assertion too short");
  chk_release_length: assert property ($fell(act) |=> !act)
    else $error("strobe release too short");
  chk_burst_addr_hold: assert property ((act && $changed(addr)) |=> ($stable(addr) || !act) [*3])
    else $error("burst address held too briefly");
  chk_direct_sel_hold: assert property ((act && $past(act)) |-> $stable(fifo_direct_select))
    else $error("direct select moved in a cycle");
  chk_strobes_apart: assert property (!(!read_strobe_n && !write_strobe_n))
    else $error("read and write strobes both low");
  chk_word_data_hold: assert property ((rd_on && $changed(dev_data_out)) |=>
    $stable(dev_data_out) [*3])
    else $error("read data moved within a word");

  cover property (rd_on && $changed(addr));
  cover property (rd_on && fifo_direct_select);
  cover property ($fell(wr_on));
endmodule : host_bus_monitor

// File: test/tb.sv
// Self-checking bench: host end and device end joined by one host_bus_if,
// plus a second device end whose pins the bench drives itself.
// Assumes the host_bus_pkg constants and a 25 MHz sys_clk.
`timescale 1ns/1ps
module tb;
  import host_bus_pkg::*;
  logic              sys_clk, reset, cmd_valid, cmd_ready, cmd_write, cmd_direct, rsp_valid;
  logic [ADDR_W-1:0] cmd_addr, csr_addr, wr_addr, csr_addr2;
  logic [DATA_W-1:0] cmd_wdata, rsp_data, wr_data, wr_data2, wire_wdata;
  logic [7:0]        cmd_words;
  logic              latch, wr_en, wr_sel, rx_pop, rxs_pop, txs_pop, overrun, overrun2;
  int                fails = 0, total_checks = 0, cycles = 0, latches = 0, writes = 0;
  int                rx_head = 0, rxs_head = 0, txs_head = 0;
  logic [DATA_W-1:0] rsp_q[$];
  host_bus_if bus();
  host_bus_if bus2();

  host_port_master host_port_master_inst (.sys_clk(sys_clk), .reset(reset), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_direct(cmd_direct), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_words(cmd_words), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  host_port_device host_port_device_inst (.sys_clk(sys_clk), .reset(reset), .bus(bus),
    .csr_addr(csr_addr), .csr_rd_data({9'h180, csr_addr}), .counter_latch(latch),
    .csr_wr_en(wr_en), .csr_wr_addr(wr_addr), .csr_wr_data(wr_data),
    .csr_wr_fifo_sel(wr_sel), .rx_data_word(16'hD000 + 16'(rx_head)), .rx_data_lane(),
    .rx_data_pop(rx_pop), .rx_status_word(16'hA000 + 16'(rxs_head)),
    .rx_status_pop(rxs_pop), .tx_status_word(16'hB000 + 16'(txs_head)),
    .tx_status_pop(txs_pop), .burst_overrun(overrun));
  host_port_device host_port_device_inst_b (.sys_clk(sys_clk), .reset(reset), .bus(bus2),
    .csr_addr(csr_addr2), .csr_rd_data({9'h180, csr_addr2}), .counter_latch(),
    .csr_wr_en(), .csr_wr_addr(), .csr_wr_data(wr_data2), .csr_wr_fifo_sel(),
    .rx_data_word(16'h0000), .rx_data_lane(), .rx_data_pop(), .rx_status_word(16'h0000),
    .rx_status_pop(), .tx_status_word(16'h0000), .tx_status_pop(), .burst_overrun(overrun2));
  host_bus_monitor host_bus_monitor_inst (.sys_clk(sys_clk), .reset(reset),
    .host_select_n(bus.host_select_n), .read_strobe_n(bus.read_strobe_n),
    .write_strobe_n(bus.write_strobe_n), .fifo_direct_select(bus.fifo_direct_select),
    .addr(bus.addr), .host_data_out(bus.host_data_out), .host_data_oe(bus.host_data_oe),
    .dev_data_out(bus.dev_data_out), .dev_data_oe(bus.dev_data_oe), .data_bus(bus.data_bus));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Far-side FIFO heads advance on each pop; responses and wire data are logged.
  always @(posedge sys_clk)
  begin
    if (rx_pop === 1'b1) rx_head <= rx_head + 1;
    if (rxs_pop === 1'b1) rxs_head <= rxs_head + 1;
    if (txs_pop === 1'b1) txs_head <= txs_head + 1;
    if (latch === 1'b1) latches <= latches + 1;
    if (wr_en === 1'b1) writes <= writes + 1;
    if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
    if (!bus.host_select_n && !bus.write_strobe_n) wire_wdata <= bus.data_bus;
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails++;
      give_verdict();
    end
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic run_cmd(input logic wr, input logic dir, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, input logic [7:0] n);
    int k;
    @(negedge sys_clk);
    {cmd_valid, cmd_write, cmd_direct, cmd_addr, cmd_wdata, cmd_words} = {1'b1, wr, dir, a, d, n};
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 300)
    begin
      @(negedge sys_clk);
      k++;
    end
    repeat (2) @(negedge sys_clk);
  endtask : run_cmd

  task automatic read_seq(input logic dir, input logic [ADDR_W-1:0] a, input logic [7:0] n,
                          input logic [DATA_W-1:0] first, input logic [DATA_W-1:0] step);
    logic [7:0] exp_n;
    // Normal bursts stop at the word limit; direct bursts do not.
    exp_n = (!dir && n > 8'(BURST_MAX_WORDS)) ? 8'(BURST_MAX_WORDS) : n;
    rsp_q.delete();
    run_cmd(1'b0, dir, a, 16'h0000, n);
    check(16'(rsp_q.size()), {8'h00, exp_n});
    foreach (rsp_q[i]) check(rsp_q[i], first + step * 16'(i));
  endtask : read_seq

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    {cmd_valid, cmd_write, cmd_direct, cmd_addr, cmd_wdata, cmd_words} = '0;
    reset = 1'b1;
    {bus2.host_select_n, bus2.read_strobe_n, bus2.write_strobe_n} = 3'b111;
    {bus2.fifo_direct_select, bus2.addr, bus2.host_data_out, bus2.host_data_oe} = '0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    check(bus.data_bus, BUS_PULL_VALUE);
    read_seq(1'b0, CSR_BASE, 1, 16'hC028, 0);
    read_seq(1'b0, RXS_BASE, 2, 16'hA000, 1);
    read_seq(1'b0, TXS_BASE, 1, 16'hB000, 0);
    read_seq(1'b0, 7'h10, 1, 16'h0000, 0);
    check(16'(latches), 16'h0004);
    $display("single reads done");
    read_seq(1'b0, CSR_BASE, 16, 16'hC028, 1);
    check({15'h0, overrun}, 16'h0000);
    read_seq(1'b0, CSR_BASE, 17, 16'hC028, 1);
    check({15'h0, overrun}, 16'h0000);
    read_seq(1'b0, RXD_BASE, 3, 16'hD000, 1);
    $display("bursts done");
    read_seq(1'b1, 7'h7C, 20, 16'hD003, 1);
    check({15'h0, overrun}, 16'h0000);
    check(16'(rx_head), 16'h0017);
    $display("direct reads done");
    run_cmd(1'b1, 1'b0, 7'h30, 16'h5A3C, 1);
    check({wr_sel, wr_addr, 8'h00}, 16'h3000);
    check(wr_data, 16'h5A3C);
    check(wire_wdata, 16'h5A3C);
    run_cmd(1'b1, 1'b1, 7'h05, 16'hC3A5, 1);
    check({wr_sel, wr_data[14:0]}, 16'hC3A5);
    check(16'(writes), 16'h0002);
    $display("writes done");
    @(negedge sys_clk);
    {bus2.addr, bus2.read_strobe_n} = {7'h2A, 1'b0};
    @(negedge sys_clk);
    bus2.host_select_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    check(bus2.data_bus, 16'hC02A);
    bus2.host_select_n = 1'b1;
    @(negedge sys_clk);
    check(bus2.data_bus, BUS_PULL_VALUE);
    bus2.read_strobe_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    {bus2.host_select_n, bus2.host_data_out, bus2.host_data_oe} = {1'b0, 16'h1234, 1'b1};
    @(negedge sys_clk);
    bus2.write_strobe_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    bus2.write_strobe_n = 1'b1;
    @(negedge sys_clk);
    {bus2.host_select_n, bus2.host_data_oe} = 2'b10;
    repeat (3) @(negedge sys_clk);
    check(wr_data2, 16'h1234);
    $display("strobe order done");
    // A pin-driven normal burst one word past the limit raises the overrun flag.
    {bus2.addr, bus2.host_select_n, bus2.read_strobe_n} = {CSR_BASE, 2'b00};
    for (int i = 0; i < 16; i++)
    begin
      repeat (3) @(negedge sys_clk);
      check(bus2.data_bus, 16'hC028 + 16'(i));
      check({15'h0, overrun2}, 16'h0000);
      bus2.addr = bus2.addr + 7'h01;
    end
    repeat (3) @(negedge sys_clk);
    check(bus2.data_bus, 16'hC038);
    check({15'h0, overrun2}, 16'h0001);
    {bus2.host_select_n, bus2.read_strobe_n} = 2'b11;
    $display("overrun done");
    give_verdict();
  end
endmodule : tb
